/* design/ams_chan_pick.sv */
// finds the lowest set mask bit at or above a start index
// purely combinational; the caller registers the result
`timescale 1ns/100ps
`default_nettype none

module ams_chan_pick #(
    parameter int N  = 8,
    parameter int CW = 3
) (
    // request
    input  wire logic [N-1:0]  mask_i,
    input  wire logic [CW:0]   from_i,
    // answer
    output logic               found_o,
    output logic [CW-1:0]      idx_o
);

    logic [N-1:0] hit;

    for (genvar gi = 0; gi < N; gi++) begin : g_hit
        assign hit[gi] = mask_i[gi] && ((CW+1)'(gi) >= from_i);
    end

    assign found_o = |hit;

    always_comb begin
        idx_o = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (hit[i]) begin
                idx_o = CW'(i);
            end
        end
    end

endmodule
`default_nettype wire

/* design/ams_fall_sync.sv */
// two-flop synchroniser with falling edge detector for the trigger pin
// assumes the pin is asynchronous to clock_i and idles high
`timescale 1ns/100ps
`default_nettype none
`include "ams_regs.svh"

module ams_fall_sync (
    // clock and reset
    input  wire logic clock_i,
    input  wire logic resetn_i,
    // pin and edge
    input  wire logic pin_i,
    output logic      fall_o
);

    logic meta_r;
    logic sync_r;
    logic last_r;

    // only sync_r reads meta_r
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_r <= `AMS_PIN_IDLE;
            sync_r <= `AMS_PIN_IDLE;
            last_r <= `AMS_PIN_IDLE;
        end else begin
            meta_r <= pin_i;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign fall_o = last_r & ~sync_r;

endmodule
`default_nettype wire

/* design/ams_sequencer.sv */
// converter mode sequencer: channel order, triggers, repeats, results, done event
// assumes the front end answers each conv_start_o with one conv_done_i pulse
`timescale 1ns/100ps
`default_nettype none
`include "ams_regs.svh"

module ams_sequencer #(
    parameter int NCH = `AMS_NCH,
    parameter int RW  = `AMS_RES_W,
    parameter int CW  = $clog2(NCH)
) (
    // clock and reset
    input  wire logic                   clock_i,
    input  wire logic                   resetn_i,
    // configuration, taken at start
    input  wire ams_pkg::ams_mode_t     mode_i,
    input  wire logic [CW-1:0]          chan_i,
    input  wire logic [NCH-1:0]         chan_sel_i,
    input  wire logic                   module_i,
    input  wire ams_pkg::ams_trig_t     trig_src_i,
    input  wire ams_pkg::ams_trig_t     grp1_trig_src_i,
    input  wire ams_pkg::ams_irqsel_t   irq_sel_i,
    // control
    input  wire logic                   start_i,
    input  wire logic                   stop_i,
    // trigger sources
    input  wire logic                   hw_trig_i,
    input  wire logic                   grp1_hw_trig_i,
    input  wire logic                   first_delay_timer_uf_i,
    input  wire logic                   second_delay_timer_uf_i,
    input  wire logic                   ext_conv_trigger_pin_i,
    // analog front end
    output logic                        conv_start_o,
    output logic [CW-1:0]               conv_chan_o,
    output logic                        simul_sample_o,
    input  wire logic                   conv_done_i,
    input  wire logic [RW-1:0]          conv_data_i,
    // results and status
    output logic [NCH*RW-1:0]           result_o,
    output logic [NCH-1:0]              result_upd_o,
    output logic                        busy_o,
    output logic                        conversion_done_irq_o
);
    import ams_pkg::*;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    ams_state_t   state_r, state_nxt;
    ams_mode_t    mode_r;
    ams_trig_t    trig0_r, trig1_r;
    ams_irqsel_t  irqsel_r;
    logic [NCH-1:0] mask_r, mask_in, act_mask;
    logic           module_r, phase_r;
    logic [CW:0]    from_r;
    logic [CW-1:0]  cur_r, pick_idx, mod_base, mod_base_in, grp_base;
    logic [1:0]     pend_r, gdone_r;
    logic [RW-1:0]  result_r [NCH];
    logic [NCH-1:0] result_upd_r;
    logic           conv_start_r, simul_r, irq_r, busy_r;
    logic           pin_fall, found, hw0_evt, hw1_evt, go0, arm_evt, hold_evt;
    logic           is_dly, is_scan2, is_dly_in, is_scan2_in, keep_on, pass_end, conv_fin;
    logic           start_ok, irq_evt, both_done;

    function automatic logic trig_evt(ams_trig_t s, logic hw, logic pin);
        return (s == AMS_TRG_HW) ? hw : ((s == AMS_TRG_PIN) ? pin : 1'b0);
    endfunction

    ams_fall_sync u_pin (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .pin_i    (ext_conv_trigger_pin_i),
        .fall_o   (pin_fall)
    );

    ams_chan_pick #(.N(NCH), .CW(CW)) u_pick (
        .mask_i  (act_mask),
        .from_i  (from_r),
        .found_o (found),
        .idx_o   (pick_idx)
    );

    // mode decode
    assign is_dly      = (mode_r == AMS_DLY0) || (mode_r == AMS_DLY1);
    assign is_scan2    = (mode_r == AMS_SCAN2) || (mode_r == AMS_SCAN2C);
    assign is_dly_in   = (mode_i == AMS_DLY0) || (mode_i == AMS_DLY1);
    assign is_scan2_in = (mode_i == AMS_SCAN2) || (mode_i == AMS_SCAN2C);
    assign keep_on     = mode_r inside {AMS_REPEAT, AMS_RSWEEP0, AMS_RSWEEP1,
                                        AMS_SCAN2C, AMS_SCAN4C};
    assign mod_base    = module_r ? CW'(`AMS_MOD_CH) : '0;
    assign mod_base_in = module_i ? CW'(`AMS_MOD_CH) : '0;
    assign grp_base    = mod_base + (phase_r ? CW'(`AMS_GRP_CH) : '0);

    // channel mask captured at start
    always_comb begin
        unique case (mode_i)
            AMS_SINGLE, AMS_REPEAT:
                mask_in = NCH'(1) << chan_i;
            AMS_SIMUL, AMS_DLY0, AMS_DLY1:
                mask_in = chan_sel_i | NCH'(2'h3);
            AMS_SCAN2, AMS_SCAN2C, AMS_SCAN4, AMS_SCAN4C:
                mask_in = chan_sel_i & (NCH'(4'hF) << mod_base_in);
            default:
                mask_in = chan_sel_i;
        endcase
    end

    // pass mask: sweep 1 runs selected then the rest, scan2 one group per phase
    always_comb begin
        if (mode_r == AMS_RSWEEP1) begin
            act_mask = phase_r ? ~mask_r : mask_r;
        end else if (is_scan2) begin
            act_mask = mask_r & (NCH'(2'h3) << grp_base);
        end else begin
            act_mask = mask_r;
        end
    end

    assign hw0_evt  = trig_evt(trig0_r, hw_trig_i, pin_fall);
    assign hw1_evt  = trig_evt(trig1_r, grp1_hw_trig_i, pin_fall);
    assign go0      = pend_r[0] | hw0_evt;
    assign hold_evt = (mode_r == AMS_DLY0) ? second_delay_timer_uf_i : pin_fall;
    assign start_ok = start_i && !stop_i && (state_r == AMS_ST_IDLE);
    assign pass_end = (state_r == AMS_ST_PICK) && !found;
    assign conv_fin = (state_r == AMS_ST_CONV) && conv_done_i;

    always_comb begin
        unique case (mode_r)
            AMS_DLY0:              arm_evt = first_delay_timer_uf_i;
            AMS_DLY1:              arm_evt = pin_fall;
            AMS_SCAN2, AMS_SCAN2C: arm_evt = go0 | pend_r[1] | hw1_evt;
            default:               arm_evt = hw0_evt;
        endcase
    end

    // done event selection
    assign both_done = (gdone_r | (2'h1 << phase_r)) == 2'h3;
    always_comb begin
        if (!pass_end) begin
            irq_evt = 1'b0;
        end else if (is_scan2) begin
            unique case (irqsel_r)
                AMS_IRQ_G0: irq_evt = !phase_r;
                AMS_IRQ_G1: irq_evt = phase_r;
                default:    irq_evt = both_done;
            endcase
        end else if (mode_r == AMS_RSWEEP1) begin
            irq_evt = phase_r;
        end else begin
            irq_evt = 1'b1;
        end
    end

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            AMS_ST_IDLE: begin
                if (start_ok) begin
                    // hardware sources wait for their first event
                    if (is_dly_in || is_scan2_in || trig_src_i != AMS_TRG_SW) begin
                        state_nxt = AMS_ST_ARMED;
                    end else begin
                        state_nxt = AMS_ST_PICK;
                    end
                end
            end
            AMS_ST_ARMED: begin
                if (arm_evt) begin
                    state_nxt = AMS_ST_PICK;
                end
            end
            AMS_ST_PICK: begin
                if (found) begin
                    state_nxt = AMS_ST_CONV;
                end else if (keep_on) begin
                    state_nxt = AMS_ST_PICK;
                end else if (is_scan2) begin
                    state_nxt = AMS_ST_ARMED;
                end else begin
                    state_nxt = AMS_ST_IDLE;
                end
            end
            AMS_ST_CONV: begin
                if (conv_done_i) begin
                    if (is_dly && cur_r == CW'(`AMS_CH_IN0)) begin
                        state_nxt = AMS_ST_HOLD;
                    end else begin
                        state_nxt = AMS_ST_PICK;
                    end
                end
            end
            AMS_ST_HOLD: begin
                if (hold_evt) begin
                    state_nxt = AMS_ST_PICK;
                end
            end
            default: state_nxt = AMS_ST_IDLE;
        endcase
        if (stop_i) begin
            state_nxt = AMS_ST_IDLE;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= AMS_ST_IDLE;
            busy_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            busy_r  <= state_nxt inside {AMS_ST_PICK, AMS_ST_CONV, AMS_ST_HOLD};
        end
    end

    // configuration snapshot; a mid-sequence change of the inputs has no effect
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_r   <= AMS_SINGLE;
            mask_r   <= '0;
            module_r <= 1'b0;
            trig0_r  <= AMS_TRG_SW;
            trig1_r  <= AMS_TRG_SW;
            irqsel_r <= AMS_IRQ_G0;
        end else if (start_ok) begin
            mode_r   <= mode_i;
            mask_r   <= mask_in;
            module_r <= module_i;
            trig0_r  <= trig_src_i;
            trig1_r  <= grp1_trig_src_i;
            irqsel_r <= irq_sel_i;
        end
    end

    // pass position
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            from_r  <= '0;
            cur_r   <= '0;
            phase_r <= 1'b0;
        end else if (start_ok) begin
            from_r  <= '0;
            phase_r <= 1'b0;
        end else if (state_r == AMS_ST_ARMED && arm_evt) begin
            from_r  <= '0;
            phase_r <= is_scan2 && !go0;
        end else if (pass_end) begin
            from_r  <= '0;
            if (mode_r == AMS_RSWEEP1 || mode_r == AMS_SCAN2C) begin
                phase_r <= !phase_r;
            end
        end else if (state_r == AMS_ST_PICK) begin
            cur_r <= pick_idx;
        end else if (conv_fin) begin
            from_r <= (CW+1)'(cur_r) + (CW+1)'(1);
        end
    end

    // group triggers are kept while the other group runs; a set beats the clear
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pend_r <= '0;
        end else if (stop_i) begin
            pend_r <= '0;
        end else if (start_ok) begin
            pend_r <= {grp1_trig_src_i == AMS_TRG_SW, trig_src_i == AMS_TRG_SW};
        end else if (is_scan2 && state_r != AMS_ST_IDLE) begin
            if (state_r == AMS_ST_ARMED && arm_evt) begin
                pend_r[0] <= go0 ? hw0_evt & pend_r[0] : pend_r[0] | hw0_evt;
                pend_r[1] <= go0 ? pend_r[1] | hw1_evt : hw1_evt & pend_r[1];
            end else begin
                pend_r <= pend_r | {hw1_evt, hw0_evt};
            end
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            gdone_r <= '0;
        end else if (start_ok) begin
            gdone_r <= '0;
        end else if (pass_end && is_scan2) begin
            gdone_r <= both_done ? 2'h0 : (gdone_r | (2'h1 << phase_r));
        end
    end

    // front end strobes
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            conv_start_r <= 1'b0;
            simul_r      <= 1'b0;
            irq_r        <= 1'b0;
        end else begin
            conv_start_r <= (state_r == AMS_ST_PICK) && found && !stop_i;
            simul_r      <= (state_r == AMS_ST_PICK) && found && !stop_i &&
                            mode_r == AMS_SIMUL && pick_idx == CW'(`AMS_CH_IN0);
            irq_r        <= irq_evt && !stop_i;
        end
    end

    // results: one register per channel
    for (genvar gi = 0; gi < NCH; gi++) begin : g_res
        always_ff @(posedge clock_i or negedge resetn_i) begin
            if (!resetn_i) begin
                result_r[gi]     <= `AMS_RST_RESULT;
                result_upd_r[gi] <= 1'b0;
            end else begin
                result_upd_r[gi] <= conv_fin && cur_r == CW'(gi);
                if (conv_fin && cur_r == CW'(gi)) begin
                    result_r[gi] <= conv_data_i;
                end
            end
        end
        assign result_o[gi*RW +: RW] = result_r[gi];
    end

    assign conv_start_o          = conv_start_r;
    assign conv_chan_o           = cur_r;
    assign simul_sample_o        = simul_r;
    assign result_upd_o          = result_upd_r;
    assign busy_o                = busy_r;
    assign conversion_done_irq_o = irq_r;

    sequence s_done_in(ams_mode_t m);
        conv_fin && mode_r == m && !stop_i;
    endsequence

    sequence s_hold_release;
        state_r == AMS_ST_HOLD && hold_evt && !stop_i ##1 !stop_i;
    endsequence

    a_single_once: assert property (s_done_in(AMS_SINGLE) ##1 !stop_i |=>
        conversion_done_irq_o && state_r == AMS_ST_IDLE && !busy_o)
        else $error("single mode did not stop after one conversion");

    a_repeat_again: assert property (s_done_in(AMS_REPEAT) ##1 !stop_i[*2] |=>
        conv_start_o && conv_chan_o == $past(cur_r, 3))
        else $error("repeat mode did not restart its channel");

    a_dly0_wait: assert property (state_r == AMS_ST_HOLD && mode_r == AMS_DLY0 &&
        !second_delay_timer_uf_i && !stop_i |=> state_r == AMS_ST_HOLD && !conv_start_o &&
        !simul_sample_o)
        else $error("input 1 converted before the second timer underflow");

    a_hold_resume: assert property (s_hold_release |=>
        conv_start_o && conv_chan_o == CW'(`AMS_CH_IN1))
        else $error("sweep did not resume with input 1");

    a_dly_first: assert property (state_r == AMS_ST_ARMED && is_dly && arm_evt &&
        !stop_i ##1 !stop_i |=> conv_start_o && conv_chan_o == CW'(`AMS_CH_IN0))
        else $error("delayed sweep did not begin with input 0");

    a_result_lane: assert property (conv_fin |=>
        result_upd_o == (NCH'(1) << $past(cur_r)) && result_r[$past(cur_r)] == $past(conv_data_i))
        else $error("result stored in the wrong channel register");

    a_busy_conv: assert property (conv_start_o |-> busy_o && state_r == AMS_ST_CONV)
        else $error("conversion started while not busy");

    a_scan2_idle: assert property (pass_end && mode_r == AMS_SCAN2 && !stop_i |=>
        state_r == AMS_ST_ARMED && !busy_o)
        else $error("two-channel scan did not go idle after its group");

    a_scan4_order: assert property (state_r == AMS_ST_PICK && found &&
        mode_r inside {AMS_SCAN4, AMS_SCAN4C} |-> pick_idx >= CW'(from_r) &&
        pick_idx[CW-1] == module_r)
        else $error("four-channel scan out of order or outside its module");

    a_scan4c_loop: assert property (pass_end && mode_r == AMS_SCAN4C && !stop_i |=>
        conversion_done_irq_o && state_r == AMS_ST_PICK && from_r == '0)
        else $error("continuous scan did not signal and restart");

    a_sw_start: assert property (start_ok && trig_src_i == AMS_TRG_SW &&
        mode_i == AMS_SINGLE ##1 !stop_i |=> conv_start_o)
        else $error("software start did not begin at once");

endmodule
`default_nettype wire

/* inc/ams_pkg.sv */
// types of the converter mode sequencer
// assumes ams_regs.svh is on the include path
`include "ams_regs.svh"

package ams_pkg;

    typedef enum logic [3:0] {
        AMS_SINGLE  = 4'h0,
        AMS_REPEAT  = 4'h1,
        AMS_SWEEP   = 4'h2,
        AMS_RSWEEP0 = 4'h3,
        AMS_RSWEEP1 = 4'h4,
        AMS_SIMUL   = 4'h5,
        AMS_DLY0    = 4'h6,
        AMS_DLY1    = 4'h7,
        AMS_SCAN2   = 4'h8,
        AMS_SCAN2C  = 4'h9,
        AMS_SCAN4   = 4'hA,
        AMS_SCAN4C  = 4'hB
    } ams_mode_t;

    typedef enum logic [1:0] {
        AMS_TRG_SW  = 2'h0,
        AMS_TRG_HW  = 2'h1,
        AMS_TRG_PIN = 2'h2
    } ams_trig_t;

    typedef enum logic [1:0] {
        AMS_IRQ_G0   = 2'h0,
        AMS_IRQ_G1   = 2'h1,
        AMS_IRQ_BOTH = 2'h2
    } ams_irqsel_t;

    // gray along idle, armed, pick, convert, hold
    typedef enum logic [2:0] {
        AMS_ST_IDLE  = 3'h0,
        AMS_ST_ARMED = 3'h1,
        AMS_ST_PICK  = 3'h3,
        AMS_ST_CONV  = 3'h2,
        AMS_ST_HOLD  = 3'h6
    } ams_state_t;

endpackage

/* inc/ams_regs.svh */
// constants of the converter mode sequencer: widths, channel numbers, reset values
// assumes a single clock domain; included by the package, the sequencer and the pin synchroniser
// How it works
// - single mode converts the chosen input once, then stops
// - repeat mode converts the chosen input again and again until stopped
// - single sweep converts every selected input once, then stops
// - repeat sweep 0 restarts the sweep of the selected inputs after each pass
// - repeat sweep 1 sweeps all inputs, selected inputs first in each pass
// - simultaneous sweep samples analog_input_0 and analog_input_1 together, sweeps once
// - delayed trigger 0 starts a sweep on first_delay_timer underflow, input 0 first
// - delayed trigger 0 holds input 1 until second_delay_timer underflows, then resumes
// - delayed trigger 1 starts a sweep on a falling trigger pin edge, input 0 first
// - delayed trigger 1 holds input 1 until the next falling pin edge
// - two-channel scan splits a module into groups 0 and 1, each with its trigger
// - two-channel scan done event after group 0, group 1, or both groups
// - two-channel scan goes idle when the triggered group has been converted
// - two-channel continuous scan keeps converting after the groups complete
// - four-channel scan converts one to four module inputs in ascending order
// - each result lands in the result register of its own channel
// - four-channel scan raises the done event after the last channel, then idles
// - four-channel continuous scan raises the done event per pass and restarts
// - hardware trigger waits for first event after arming; software starts at once, except in the delayed trigger modes
`ifndef AMS_REGS_SVH
`define AMS_REGS_SVH

`define AMS_NCH        8
`define AMS_RES_W      10
`define AMS_MOD_CH     4
`define AMS_GRP_CH     2
`define AMS_CH_IN0     0
`define AMS_CH_IN1     1
`define AMS_RST_RESULT 10'h000
`define AMS_PIN_IDLE   1'b1

`endif

/* verification/ams_front_model.sv */
// front end model: one done pulse with data for each conversion start
// assumes starts never overlap; lat_i sets how long each answer takes
`timescale 1ns/100ps
`default_nettype none
module ams_front_model (
    // clock and reset
    input  wire logic       clock_i,
    input  wire logic       resetn_i,
    // request
    input  wire logic       conv_start_i,
    input  wire logic [2:0] conv_chan_i,
    input  wire logic [3:0] lat_i,
    // answer
    output logic            conv_done_o,
    output logic [9:0]      conv_data_o
);
    logic       run_r;
    logic [3:0] wait_r;
    logic [2:0] chan_r;
    // data toggles outside the done pulse so a late sample shows up
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            run_r       <= 1'b0;
            wait_r      <= 4'h0;
            chan_r      <= 3'h0;
            conv_done_o <= 1'b0;
            conv_data_o <= 10'h000;
        end else begin
            conv_done_o <= 1'b0;
            conv_data_o <= ~conv_data_o;
            if (conv_start_i) begin
                run_r  <= 1'b1;
                wait_r <= lat_i;
                chan_r <= conv_chan_i;
            end else if (run_r && wait_r != 4'h0) begin
                wait_r <= wait_r - 4'h1;
            end else if (run_r) begin
                run_r       <= 1'b0;
                conv_done_o <= 1'b1;
                conv_data_o <= {chan_r, ~chan_r, 4'h5};
            end
        end
    end
endmodule
`default_nettype wire

/* verification/ams_sequencer_tb.sv */
// random bench of the mode sequencer, seed 77
// assumes the front end model answers every conversion start
`timescale 1ns/100ps
`default_nettype none
module ams_sequencer_tb;
    import ams_pkg::*;
    logic clock_i = 1'b0, resetn_i = 1'b0, module_i = 1'b1, start_i = 1'b0, stop_i = 1'b0;
    logic hw_trig_i = 1'b0, grp1_hw_trig_i = 1'b0, first_delay_timer_uf_i = 1'b0;
    logic second_delay_timer_uf_i = 1'b0, ext_conv_trigger_pin_i = 1'b1, conv_done_i;
    logic conv_start_o, simul_sample_o, busy_o, conversion_done_irq_o;
    logic [2:0] chan_i = 3'h0, conv_chan_o;
    logic [7:0] chan_sel_i = 8'h00, result_upd_o, m;
    logic [9:0] conv_data_i;
    logic [79:0] result_o;
    logic [63:0] ord = 64'h0, snap = 64'h0;
    logic [3:0] lat = 4'h0;
    ams_mode_t mode_i = AMS_SINGLE;
    ams_trig_t trig_src_i = AMS_TRG_SW, grp1_trig_src_i = AMS_TRG_HW;
    ams_irqsel_t irq_sel_i = AMS_IRQ_G0;
    int fail_count = 0, n_compared = 0, irq_n = 0, res_n = 0, sim_n = 0;
    always #2 clock_i = ~clock_i;
    ams_sequencer u_ams_sequencer (.clock_i, .resetn_i, .mode_i, .chan_i, .chan_sel_i,
        .module_i, .trig_src_i, .grp1_trig_src_i, .irq_sel_i, .start_i, .stop_i, .hw_trig_i,
        .grp1_hw_trig_i, .first_delay_timer_uf_i, .second_delay_timer_uf_i,
        .ext_conv_trigger_pin_i, .conv_start_o, .conv_chan_o, .simul_sample_o, .conv_done_i,
        .conv_data_i, .result_o, .result_upd_o, .busy_o, .conversion_done_irq_o);
    ams_front_model u_ams_front_model (.clock_i, .resetn_i, .conv_start_i(conv_start_o),
        .conv_chan_i(conv_chan_o), .lat_i(lat), .conv_done_o(conv_done_i),
        .conv_data_o(conv_data_i));
    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %0h", $time, what, got);
        end
    endtask
    // expected channel order, appended nibble by nibble
    function automatic logic [63:0] asc(input logic [7:0] k, input logic [63:0] acc);
        for (int i = 0; i < 8; i++) begin
            if (k[i]) acc = {acc[59:0], 4'(i)};
        end
        return acc;
    endfunction
    always @(negedge clock_i) begin
        for (int i = 0; i < 8; i++) begin
            if (result_upd_o[i] === 1'b1) begin
                ord = {ord[59:0], 4'(i)};
                res_n++;
                chk(64'(result_o[i*10+:10]), 64'({3'(i), ~3'(i), 4'h5}), "data");
            end
        end
        if (conversion_done_irq_o === 1'b1) begin
            irq_n++;
            snap = ord;
        end
        if (simul_sample_o === 1'b1) begin
            sim_n++;
            chk(64'({conv_start_o, conv_chan_o}), 64'h8, "simul");
        end
    end
    task automatic go(input ams_mode_t md, input logic [7:0] k, input ams_trig_t ts);
        @(negedge clock_i);
        {mode_i, chan_sel_i, trig_src_i} = {md, k, ts};
        {ord, irq_n, res_n} = '0;
        lat = 4'($urandom_range(0, 6));
        start_i = 1'b1;
        @(negedge clock_i);
        start_i = 1'b0;
    endtask
    // bounded wait; running out counts as a mismatch
    task automatic wait_irq(input int n);
        int k = 0;
        while (irq_n < n && k < 3000) begin
            @(negedge clock_i);
            k++;
        end
        if (irq_n < n) begin
            chk(64'h0, 64'h1, "timeout");
            end_of_test();
        end
    endtask
    task automatic stp();
        @(negedge clock_i);
        stop_i = 1'b1;
        @(negedge clock_i);
        stop_i = 1'b0;
        @(negedge clock_i);
        chk(64'(busy_o), 64'h0, "busy after stop");
    endtask
    // s: 0 first timer, 1 second timer, 2 group 0, 3 group 1, 4 pin edge
    task automatic fire(input int s);
        @(negedge clock_i);
        {grp1_hw_trig_i, hw_trig_i, second_delay_timer_uf_i, first_delay_timer_uf_i} = 4'(1 << s);
        ext_conv_trigger_pin_i = (s != 4);
        @(negedge clock_i);
        {grp1_hw_trig_i, hw_trig_i, second_delay_timer_uf_i, first_delay_timer_uf_i} = 4'h0;
        repeat (4) @(negedge clock_i);
        ext_conv_trigger_pin_i = 1'b1;
        repeat (20) @(negedge clock_i);
    endtask
    task automatic run(input ams_mode_t md, input logic [7:0] k, input logic [63:0] e,
                       input int n, input bit once);
        go(md, k, AMS_TRG_SW);
        chk(64'(busy_o), 64'h1, "sw start");
        wait_irq(n);
        chk(snap, e, "order");
        repeat (4) @(negedge clock_i);
        if (once) chk(ord, e, "stopped");
        stp();
    endtask
    initial begin
        void'($urandom(77));
        repeat (2) @(negedge clock_i);
        resetn_i = 1'b1;
        chk(64'({busy_o, |result_o}), 64'h0, "reset");
        chan_i = 3'($urandom_range(0, 7));
        run(AMS_SINGLE, 8'h00, asc(8'h1 << chan_i, 0), 1, 1);
        run(AMS_REPEAT, 8'h00, asc(8'h1 << chan_i, asc(8'h1 << chan_i, 0)), 2, 0);
        m = 8'($urandom_range(1, 255));
        run(AMS_SWEEP, m, asc(m, 0), 1, 1);
        run(AMS_RSWEEP0, m, asc(m, asc(m, 0)), 2, 0);
        run(AMS_RSWEEP1, m, asc(~m, asc(m, 0)), 1, 0);
        run(AMS_SIMUL, m, asc(m | 8'h03, 0), 1, 1);
        chk(64'(sim_n), 64'h1, "simul count");
        run(AMS_SCAN4, m | 8'h10, asc((m | 8'h10) & 8'hF0, 0), 1, 1);
        run(AMS_SCAN4C, m | 8'h10, asc(m & 8'hF0 | 8'h10, asc(m & 8'hF0 | 8'h10, 0)),
            2, 0);
        go(AMS_SWEEP, m, AMS_TRG_PIN);
        fire(2);
        chk(64'({busy_o, res_n[0]}), 64'h0, "pin armed");
        fire(4);
        wait_irq(1);
        chk(snap, asc(m, 0), "pin start");
        stp();
        for (int s = 0; s < 2; s++) begin
            go(s ? AMS_DLY1 : AMS_DLY0, m, AMS_TRG_SW);
            fire(s ? 2 : 3);
            chk(64'(busy_o), 64'h0, "armed");
            fire(s ? 4 : 0);
            chk(64'(res_n), 64'h1, "held");
            fire(s ? 4 : 1);
            wait_irq(1);
            chk(snap, asc(m | 8'h03, 0), "delayed");
            stp();
        end
        module_i = 1'b0;
        for (int s = 0; s < 3; s++) begin
            irq_sel_i = ams_irqsel_t'(s);
            go(AMS_SCAN2, 8'h0F, AMS_TRG_HW);
            fire(3);
            chk(64'({busy_o, irq_n[0]}), 64'(s == 1), "group 1");
            fire(2);
            chk(64'({busy_o, irq_n}), 64'h1, "both groups");
            chk(ord, asc(8'h03, asc(8'h0C, 0)), "groups");
            stp();
        end
        go(AMS_SCAN2C, 8'h0F, AMS_TRG_HW);
        fire(2);
        fire(3);
        chk(64'(res_n > 4), 64'h1, "continuous");
        stp();
        end_of_test();
    end
endmodule
`default_nettype wire
